// >>> src/lcf_defines.svh
/*
 * Offsets, reset values, field positions and limits of the LED current
 * and fault register slice.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef LCF_DEFINES_SVH
`define LCF_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LCF_OFS_LED1_BLANK 8'h07
`define LCF_OFS_LED1_ASSIST 8'h08
`define LCF_OFS_LED2_FLASH 8'h09
`define LCF_OFS_LED2_BLANK 8'h0a
`define LCF_OFS_LED2_ASSIST 8'h0b
`define LCF_OFS_FAULT 8'h0c
`define LCF_OFS_CAPTURE 8'h0d

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCF_RST_LED1_BLANK 8'h14
`define LCF_RST_ASSIST 8'h04
`define LCF_RST_LED2_FLASH 8'h28
`define LCF_RST_LED2_BLANK 8'h14
`define LCF_RST_FAULT 8'h00
`define LCF_RST_CAPTURE 6'h00

// ----------------------------------------------------------------
// Code limits, 12.5 mA per step
// ----------------------------------------------------------------
`define LCF_STEP_UA 12500
`define LCF_ASSIST_MAX 5'h10
`define LCF_FLASH_MAX 6'h3c
`define LCF_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Fault register bit positions
// ----------------------------------------------------------------
`define LCF_BIT_OVP 7
`define LCF_BIT_SC 6
`define LCF_BIT_OT 5
`define LCF_BIT_TO 4
`define LCF_BIT_TX 3
`define LCF_BIT_VB 2
`define LCF_BIT_IL 1
`define LCF_BIT_IDC 0

`endif

// >>> src/lcf_pkg.sv
/*
 * Types of the LED current and fault register slice.
 * Assumes lcf_defines.svh is on the include path.
 */
`include "lcf_defines.svh"

package lcf_pkg;

  // ----------------------------------------------------------------
  // Fault and status pins from the analog side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overvoltage;
    logic short_circuit;
    logic overtemperature;
    logic timeout;
    logic low_supply;
    logic inductor_limit;
    logic input_limit;
    logic transmit_blank_input;
    logic flash_active;
  } lcf_fault_pins_type;

  // ----------------------------------------------------------------
  // Clamped current codes to the current sources
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] led1_assist_level;
    logic [4:0] led2_assist_level;
    logic [5:0] led1_blank_level;
    logic [5:0] led2_flash_level;
    logic [5:0] led2_blank_level;
    logic [5:0] led2_active_level;
  } lcf_levels_type;

endpackage : lcf_pkg

// >>> src/lcf_regs.sv
/*
 * LED current and fault register slice of a dual LED flash driver.
 * Holds torch, flash and blanking current codes, the fault register and
 * the dc-limit capture of the LED1 flash code. Assumes the serial port
 * engine presents decoded register accesses on ref_clk, and that the
 * analog fault pins are asynchronous.
 */
`timescale 1ns/1ns

`include "lcf_defines.svh"

module lcf_regs
  import lcf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register access from the serial port engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Settings held in neighbouring registers
  input wire logic [2:0] low_supply_threshold,
  input wire logic input_limit_enable,
  input wire logic [5:0] led1_flash_level,
  // Analog fault pins
  input wire lcf_fault_pins_type fault_pins,
  // Current codes to the current sources
  output lcf_levels_type levels
);

  // ----------------------------------------------------------------
  // Code clamps
  // ----------------------------------------------------------------
  function automatic logic [4:0] clamp_assist(input logic [7:0] raw);
    logic [4:0] code;
    code = raw[4:0];
    if (code >= `LCF_ASSIST_MAX)
      return `LCF_ASSIST_MAX;
    return code;
  endfunction : clamp_assist

  function automatic logic [5:0] clamp_flash(input logic [7:0] raw);
    logic [5:0] code;
    code = raw[5:0];
    if (code >= `LCF_FLASH_MAX)
      return `LCF_FLASH_MAX;
    return code;
  endfunction : clamp_flash

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  lcf_fault_pins_type pins_s;
  logic [8:0] pins_raw;

  lcf_sync #(
    .WIDTH(9)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(fault_pins),
    .sync_out(pins_raw)
  );

  assign pins_s = lcf_fault_pins_type'(pins_raw);

  // ----------------------------------------------------------------
  // Read/write current registers
  // ----------------------------------------------------------------
  logic [7:0] led1_blank_q;
  logic [7:0] led1_assist_q;
  logic [7:0] led2_flash_q;
  logic [7:0] led2_blank_q;
  logic [7:0] led2_assist_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      led1_blank_q <= `LCF_RST_LED1_BLANK;
      led1_assist_q <= `LCF_RST_ASSIST;
      led2_flash_q <= `LCF_RST_LED2_FLASH;
      led2_blank_q <= `LCF_RST_LED2_BLANK;
      led2_assist_q <= `LCF_RST_ASSIST;
    end else if (reg_wr) begin
      // Full byte stored so reserved bits read back
      case (reg_addr)
        `LCF_OFS_LED1_BLANK: led1_blank_q <= reg_wdata;
        `LCF_OFS_LED1_ASSIST: led1_assist_q <= reg_wdata;
        `LCF_OFS_LED2_FLASH: led2_flash_q <= reg_wdata;
        `LCF_OFS_LED2_BLANK: led2_blank_q <= reg_wdata;
        `LCF_OFS_LED2_ASSIST: led2_assist_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Current codes out
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      levels <= '0;
    end else begin
      levels.led1_assist_level <= clamp_assist(led1_assist_q);
      levels.led2_assist_level <= clamp_assist(led2_assist_q);
      levels.led1_blank_level <= clamp_flash(led1_blank_q);
      levels.led2_flash_level <= clamp_flash(led2_flash_q);
      levels.led2_blank_level <= clamp_flash(led2_blank_q);
      // Blanking code replaces flash code while the mask pin is high
      levels.led2_active_level <= pins_s.transmit_blank_input ?
        clamp_flash(led2_blank_q) : clamp_flash(led2_flash_q);
    end
  end

  // ----------------------------------------------------------------
  // Fault register
  // ----------------------------------------------------------------
  logic [7:0] fault_q;
  logic flash_d1_q;
  logic idc_live;
  logic vb_live;
  logic flash_rise;
  logic fault_read;

  assign vb_live = pins_s.low_supply &&
                   (low_supply_threshold != 3'h0);
  assign idc_live = pins_s.input_limit && input_limit_enable;
  assign flash_rise = pins_s.flash_active && !flash_d1_q;
  assign fault_read = reg_rd && (reg_addr == `LCF_OFS_FAULT);

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      flash_d1_q <= 1'b0;
    else
      flash_d1_q <= pins_s.flash_active;
  end

  // Latched faults other than the blank flag clear on read; a fault present in that cycle wins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fault_q <= `LCF_RST_FAULT;
    end else begin
      fault_q[`LCF_BIT_OVP] <= pins_s.overvoltage ||
        (fault_q[`LCF_BIT_OVP] && !fault_read);
      fault_q[`LCF_BIT_SC] <= pins_s.short_circuit ||
        (fault_q[`LCF_BIT_SC] && !fault_read);
      fault_q[`LCF_BIT_OT] <= pins_s.overtemperature ||
        (fault_q[`LCF_BIT_OT] && !fault_read);
      fault_q[`LCF_BIT_TO] <= pins_s.timeout ||
        (fault_q[`LCF_BIT_TO] && !fault_read);
      fault_q[`LCF_BIT_IL] <= pins_s.inductor_limit ||
        (fault_q[`LCF_BIT_IL] && !fault_read);
      // Blank flag covers the latest flash only
      if (pins_s.flash_active && pins_s.transmit_blank_input)
        fault_q[`LCF_BIT_TX] <= 1'b1;
      else if (flash_rise)
        fault_q[`LCF_BIT_TX] <= 1'b0;
      fault_q[`LCF_BIT_VB] <= vb_live;
      fault_q[`LCF_BIT_IDC] <= idc_live;
    end
  end

  // ----------------------------------------------------------------
  // Dc limit capture of LED1 flash code
  // ----------------------------------------------------------------
  logic [5:0] capture_q;
  logic idc_d1_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      capture_q <= `LCF_RST_CAPTURE;
      idc_d1_q <= 1'b0;
    end else begin
      idc_d1_q <= idc_live;
      if (idc_live && !idc_d1_q)
        capture_q <= led1_flash_level;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `LCF_OFS_LED1_BLANK: reg_rdata <= led1_blank_q;
          `LCF_OFS_LED1_ASSIST: reg_rdata <= led1_assist_q;
          `LCF_OFS_LED2_FLASH: reg_rdata <= led2_flash_q;
          `LCF_OFS_LED2_BLANK: reg_rdata <= led2_blank_q;
          `LCF_OFS_LED2_ASSIST: reg_rdata <= led2_assist_q;
          `LCF_OFS_FAULT: reg_rdata <= fault_q;
          `LCF_OFS_CAPTURE: reg_rdata <= {2'b00, capture_q};
          default: reg_rdata <= `LCF_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_assist_big_write(logic [7:0] ofs);
    reg_wr && reg_addr == ofs && reg_wdata[4:0] >= 5'h10;
  endsequence

  sequence s_idc_rise;
    idc_live && !idc_d1_q;
  endsequence

  a_led1_assist_clamp: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    s_assist_big_write(`LCF_OFS_LED1_ASSIST) ##1 !reg_wr [*2]
    |-> levels.led1_assist_level == 5'h10)
    else $error("led1 assist level not clamped");

  a_led2_assist_track: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `LCF_OFS_LED2_ASSIST && reg_wdata[4:0] < 5'h10
    ##1 !reg_wr
    |=> levels.led2_assist_level == $past(reg_wdata[4:0], 2))
    else $error("led2 assist level does not follow write");

  a_led1_assist_track: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `LCF_OFS_LED1_ASSIST && reg_wdata[4:0] < 5'h10
    ##1 !reg_wr
    |=> levels.led1_assist_level == $past(reg_wdata[4:0], 2))
    else $error("led1 assist level does not follow write");

  a_flash_clamp_max: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    levels.led2_flash_level <= 6'h3c && levels.led2_blank_level <= 6'h3c)
    else $error("led2 flash or blank level above 750 mA");

  a_reset_values: assert property (@(posedge ref_clk)
    $fell(resetn) ##1 !reg_wr
    |-> led1_assist_q == 8'h04 && led2_assist_q == 8'h04 &&
        led2_flash_q == 8'h28 && led2_blank_q == 8'h14 && fault_q == 8'h00)
    else $error("register reset values wrong");

  a_fault_write_ignored: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `LCF_OFS_FAULT && fault_q == 8'h00 &&
    pins_s == '0 |=> fault_q == 8'h00)
    else $error("write altered fault register");

  a_fault_sticky_ovp: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pins_s.overvoltage |=> fault_q[`LCF_BIT_OVP] ##1
      (fault_q[`LCF_BIT_OVP] || $past(fault_read)))
    else $error("overvoltage flag not held");

  a_timeout_flag: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    $rose(pins_s.timeout) |=> fault_q[`LCF_BIT_TO])
    else $error("timeout flag not set");

  a_inductor_flag: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pins_s.inductor_limit |=> fault_q[`LCF_BIT_IL])
    else $error("inductor limit flag not set");

  a_blank_flag: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    flash_rise && !pins_s.transmit_blank_input |=> !fault_q[`LCF_BIT_TX])
    else $error("blank flag not cleared at new flash");

  a_low_supply_gate: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    low_supply_threshold == 3'h0 |=> !fault_q[`LCF_BIT_VB])
    else $error("low supply flag set while detection off");

  a_input_limit_gate: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !input_limit_enable |=> !fault_q[`LCF_BIT_IDC])
    else $error("input limit flag set while disabled");

  a_input_limit_live: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    idc_live |=> fault_q[`LCF_BIT_IDC])
    else $error("input limit flag not reported");

  a_capture_on_limit: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    s_idc_rise |=> capture_q == $past(led1_flash_level))
    else $error("led1 flash level not captured");

  a_capture_reserved: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    reg_rd && reg_addr == `LCF_OFS_CAPTURE |=> reg_rdata[7:6] == 2'b00)
    else $error("capture reserved bits not zero");

  a_low_supply_live: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    vb_live |=> fault_q[`LCF_BIT_VB])
    else $error("low supply flag not reported");

endmodule : lcf_regs

// >>> src/lcf_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous level inputs.
 * Assumes inputs may change at any time relative to ref_clk.
 */
`timescale 1ns/1ns

module lcf_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule : lcf_sync

// >>> tb/lcf_host_model.sv
/*
 * Host side of the register port: single-byte writes and reads.
 * Assumes decoded accesses taken at ref_clk rising edges.
 */
`timescale 1ns/1ns

module lcf_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    for (i = 0; i < 3 && !ok; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(posedge ref_clk);
      end
    end
    reg_addr <= ~a;
  endtask : rd
endmodule : lcf_host_model

// >>> tb/lcf_regs_tb.sv
/*
 * Self-checking bench of the LED current and fault register slice.
 * Assumes the design files and lcf_host_model are compiled first.
 */
`timescale 1ns/1ns

module lcf_regs_tb
  import lcf_pkg::*;
;
  logic ref_clk, resetn;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [2:0] low_supply_threshold;
  logic input_limit_enable;
  logic [5:0] led1_flash_level;
  lcf_fault_pins_type fp;
  lcf_levels_type levels;
  int n_fail = 0;
  int compares = 0;
  int i;
  localparam logic [33:0] LV_RST = {5'h04, 5'h04, 6'h14, 6'h28, 6'h14,
                                    6'h28};
  // Rows: offset, write data, read back
  logic [23:0] rows [8] = '{24'h081f1f, 24'h0be3e3, 24'h093f3f,
    24'h0a3d3d, 24'h071515, 24'h0cff00, 24'h0dff00, 24'h205500};
  logic [7:0] rst_val [7] = '{8'h14, 8'h04, 8'h28, 8'h14, 8'h04, 8'h00,
                              8'h00};
  int pin_idx [5] = '{8, 7, 6, 5, 3};
  logic [7:0] pin_bit [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02};

  lcf_regs uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .low_supply_threshold(low_supply_threshold),
    .input_limit_enable(input_limit_enable),
    .led1_flash_level(led1_flash_level), .fault_pins(fp),
    .levels(levels));

  lcf_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Checks and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("BAD rvalid at %h expected 1 seen 0", a);
      print_verdict;
    end
    if (d !== e) begin
      n_fail++;
      $display("BAD reg %h expected %h seen %h", a, e, d);
    end
  endtask : rchk

  task automatic lchk(input logic [33:0] e);
    compares++;
    if (levels !== e) begin
      n_fail++;
      $display("BAD levels expected %h seen %h", e, levels);
    end
  endtask : lchk

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    low_supply_threshold = 3'h0;
    input_limit_enable = 1'b0;
    led1_flash_level = 6'h00;
    fp = '0;
    do_reset;
    lchk(LV_RST);
    for (i = 0; i < 7; i++) begin
      rchk(8'h07 + i[7:0], rst_val[i]);
    end
    for (i = 0; i < 8; i++) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    repeat (2) @(posedge ref_clk);
    lchk({5'h10, 5'h03, 6'h15, 6'h3c, 6'h3c, 6'h3c});
    host.wr(8'h08, 8'h0f);
    host.wr(8'h0b, 8'h10);
    host.wr(8'h09, 8'h3b);
    repeat (2) @(posedge ref_clk);
    lchk({5'h0f, 5'h10, 6'h15, 6'h3b, 6'h3c, 6'h3b});
    // Latched faults, then clear on read
    for (i = 0; i < 5; i++) begin
      fp[pin_idx[i]] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      fp[pin_idx[i]] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rchk(8'h0c, pin_bit[i]);
      rchk(8'h0c, 8'h00);
    end
    // Live status gated by enables, capture on dc limit
    fp.low_supply <= 1'b1;
    fp.input_limit <= 1'b1;
    led1_flash_level <= 6'h2a;
    repeat (4) @(posedge ref_clk);
    rchk(8'h0c, 8'h00);
    low_supply_threshold <= 3'h3;
    input_limit_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rchk(8'h0c, 8'h05);
    rchk(8'h0d, 8'h2a);
    led1_flash_level <= 6'h11;
    host.wr(8'h0d, 8'hff);
    rchk(8'h0d, 8'h2a);
    fp.low_supply <= 1'b0;
    fp.input_limit <= 1'b0;
    input_limit_enable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rchk(8'h0c, 8'h00);
    // Blanking during a flash
    host.wr(8'h0a, 8'h11);
    fp.flash_active <= 1'b1;
    fp.transmit_blank_input <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lchk({5'h0f, 5'h10, 6'h15, 6'h3b, 6'h11, 6'h11});
    rchk(8'h0c, 8'h08);
    fp.flash_active <= 1'b0;
    fp.transmit_blank_input <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rchk(8'h0c, 8'h08);
    fp.flash_active <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rchk(8'h0c, 8'h00);
    lchk({5'h0f, 5'h10, 6'h15, 6'h3b, 6'h11, 6'h3b});
    // Second reset in mid-run
    fp.overvoltage <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fp <= '0;
    do_reset;
    lchk(LV_RST);
    repeat (2) @(posedge ref_clk);
    rchk(8'h0c, 8'h00);
    rchk(8'h0a, 8'h14);
    print_verdict;
  end
endmodule : lcf_regs_tb
